// ---- common/irs_pkg.sv ----
/*
 Package for the input routing switch control block: register indices,
 field positions, reset values and selector encodings.
 Assumes a plain register port with byte-wide registers at their printed offsets.
*/
package irs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_CH = 3;
	localparam int NUM_IN = 5;
	localparam logic [7:0] CH_TWO_ROUTING_ADDR = 8'h02;
	localparam logic [7:0] CH_THREE_ROUTING_ADDR = 8'h03;
	localparam logic [7:0] PACING_ROUTING_ADDR = 8'h04;
	localparam int TEST_MSB = 7;
	localparam int TEST_LSB = 6;
	localparam int PLUS_MSB = 5;
	localparam int PLUS_LSB = 3;
	localparam int MINUS_MSB = 2;
	localparam int MINUS_LSB = 0;
	localparam logic [7:0] ROUTING_RESET = 8'h00;
	localparam logic [1:0] TEST_NONE = 2'h0;
	localparam logic [1:0] TEST_POSITIVE = 2'h1;
	localparam logic [1:0] TEST_NEGATIVE = 2'h2;
	localparam logic [1:0] TEST_ZERO = 2'h3;
	localparam logic [2:0] SOURCE_OPEN = 3'h0;
	localparam logic [2:0] SOURCE_LAST = 3'h5;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ---- design/irs_decode.sv ----
/*
 Decoder of one routing register into analog switch enables.
 Assumes the register value is already synchronous to the caller's clock.
*/
`timescale 1ns/1ns
module irs_decode (
	// Register value
	input wire logic [7:0] routing,
	// Switch enables
	output logic [4:0] plusSwitch,
	output logic [4:0] minusSwitch,
	output logic [2:0] testSwitch
);
	logic [1:0] testSel;
	logic [2:0] plusSel;
	logic [2:0] minusSel;

	// One-hot over electrode inputs; 000 and 110..111 close nothing
	function automatic logic [4:0] source_onehot(input logic [2:0] sel);
		logic [4:0] hot;
		hot = 5'h00;
		if (sel != irs_pkg::SOURCE_OPEN && sel <= irs_pkg::SOURCE_LAST) begin
			hot[sel - 3'h1] = 1'b1;
		end
		return hot;
	endfunction

	always_comb begin
		testSel = routing[irs_pkg::TEST_MSB:irs_pkg::TEST_LSB];
		plusSel = routing[irs_pkg::PLUS_MSB:irs_pkg::PLUS_LSB];
		minusSel = routing[irs_pkg::MINUS_MSB:irs_pkg::MINUS_LSB];
		testSwitch = 3'h0;
		plusSwitch = 5'h00;
		minusSwitch = 5'h00;
		case (testSel)
			irs_pkg::TEST_POSITIVE: testSwitch = 3'h1;
			irs_pkg::TEST_NEGATIVE: testSwitch = 3'h2;
			irs_pkg::TEST_ZERO: testSwitch = 3'h4;
			default: begin
				plusSwitch = source_onehot(plusSel);
				minusSwitch = source_onehot(minusSel);
			end
		endcase
	end
endmodule

// ---- design/irs_routing_ctrl.sv ----
/*
 Routing control registers for channel two, channel three and the pacing channel,
 each decoded into electrode and test-signal switch enables.
 Assumes a synchronous register port driven from clk; switch outputs go to the
 analog matrix, which must tolerate combinational settling after a write.
*/
// Design decision made here: the strobed register port.
// What this block does
// - Channel two routing register at 0x02: test [7:6], plus [5:3], minus [2:0].
// - Channel three routing register at 0x03 with identical layout.
// - Pacing channel routing register at 0x04 with identical layout.
// - Minus selector 000 leaves the negative terminal open; resets to 000.
// - Minus selector 001 to 101 closes exactly one switch, inputs one to five, when the test field is 00; any test code opens all.
`timescale 1ns/1ns
module irs_routing_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Channel two switches
	output logic [4:0] chTwoPlusSwitch,
	output logic [4:0] chTwoMinusSwitch,
	output logic [2:0] chTwoTestSwitch,
	// Channel three switches
	output logic [4:0] chThreePlusSwitch,
	output logic [4:0] chThreeMinusSwitch,
	output logic [2:0] chThreeTestSwitch,
	// Pacing channel switches
	output logic [4:0] pacingPlusSwitch,
	output logic [4:0] pacingMinusSwitch,
	output logic [2:0] pacingTestSwitch
);
	logic [7:0] routing_q [3];
	logic [7:0] routing_d [3];
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;
	logic [4:0] plusSw [3];
	logic [4:0] minusSw [3];
	logic [2:0] testSw [3];

	// Address to register index; 3 means unmapped
	function automatic logic [1:0] reg_index(input logic [7:0] addr);
		if (addr == irs_pkg::CH_TWO_ROUTING_ADDR) begin
			return 2'h0;
		end else if (addr == irs_pkg::CH_THREE_ROUTING_ADDR) begin
			return 2'h1;
		end else if (addr == irs_pkg::PACING_ROUTING_ADDR) begin
			return 2'h2;
		end else begin
			return 2'h3;
		end
	endfunction

	always_comb begin
		routing_d = routing_q;
		rdData_d = irs_pkg::UNMAPPED_READ;
		if (regWrite && reg_index(regAddr) != 2'h3) begin
			routing_d[reg_index(regAddr)] = regWrData;
		end
		// Unmapped reads return zero rather than stale data
		if (regRead && reg_index(regAddr) != 2'h3) begin
			rdData_d = routing_q[reg_index(regAddr)];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < 3; i++) begin
				routing_q[i] <= irs_pkg::ROUTING_RESET;
			end
			rdData_q <= irs_pkg::UNMAPPED_READ;
		end else begin
			routing_q <= routing_d;
			rdData_q <= rdData_d;
		end
	end

	assign regRdData = rdData_q;

	generate
		for (genvar g = 0; g < 3; g++) begin : gen_dec
			irs_decode u_dec (
				.routing(routing_q[g]),
				.plusSwitch(plusSw[g]),
				.minusSwitch(minusSw[g]),
				.testSwitch(testSw[g])
			);
		end
	endgenerate

	assign chTwoPlusSwitch = plusSw[0];
	assign chTwoMinusSwitch = minusSw[0];
	assign chTwoTestSwitch = testSw[0];
	assign chThreePlusSwitch = plusSw[1];
	assign chThreeMinusSwitch = minusSw[1];
	assign chThreeTestSwitch = testSw[1];
	assign pacingPlusSwitch = plusSw[2];
	assign pacingMinusSwitch = minusSw[2];
	assign pacingTestSwitch = testSw[2];

	property p_ch_two_write;
		@(posedge clk) disable iff (!nrst)
		(regWrite && regAddr == irs_pkg::CH_TWO_ROUTING_ADDR) |=> routing_q[0] == $past(regWrData);
	endproperty
	a_ch_two_write: assert property (p_ch_two_write) else $error("channel two write lost");

	property p_ch_three_write;
		@(posedge clk) disable iff (!nrst)
		(regWrite && regAddr == irs_pkg::CH_THREE_ROUTING_ADDR) |=>
			routing_q[1] == $past(regWrData);
	endproperty
	a_ch_three_write: assert property (p_ch_three_write) else $error("channel three write lost");

	property p_pacing_readback;
		@(posedge clk) disable iff (!nrst)
		(regWrite && regAddr == irs_pkg::PACING_ROUTING_ADDR) ##1
			(regRead && regAddr == irs_pkg::PACING_ROUTING_ADDR && !regWrite)
			|=> regRdData == $past(regWrData, 2);
	endproperty
	a_pacing_readback: assert property (p_pacing_readback) else $error("pacing readback wrong");

	property p_minus_open;
		@(posedge clk) disable iff (!nrst)
		routing_q[0][2:0] == irs_pkg::SOURCE_OPEN |-> chTwoMinusSwitch == 5'h00;
	endproperty
	a_minus_open: assert property (p_minus_open) else $error("open minus closed a switch");

	property p_reset_open;
		@(posedge clk)
		!nrst |=> pacingMinusSwitch == 5'h00 && chThreeMinusSwitch == 5'h00;
	endproperty
	a_reset_open: assert property (p_reset_open) else $error("reset left a switch closed");

	property p_minus_onehot;
		@(posedge clk) disable iff (!nrst)
		(routing_q[1][7:6] == irs_pkg::TEST_NONE && routing_q[1][2:0] != 3'h0
			&& routing_q[1][2:0] <= irs_pkg::SOURCE_LAST)
			|-> chThreeMinusSwitch == (5'h01 << (routing_q[1][2:0] - 3'h1));
	endproperty
	a_minus_onehot: assert property (p_minus_onehot) else $error("minus switch not one-hot");

	property p_test_isolates;
		@(posedge clk) disable iff (!nrst)
		routing_q[2][7:6] != irs_pkg::TEST_NONE
			|-> pacingPlusSwitch == 5'h00 && $onehot(pacingTestSwitch);
	endproperty
	a_test_isolates: assert property (p_test_isolates) else $error("test and source both on");

	property p_unmapped_zero;
		@(posedge clk) disable iff (!nrst)
		(regRead && regAddr > irs_pkg::PACING_ROUTING_ADDR) |=> regRdData == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	property p_read_idle_zero;
		@(posedge clk) disable iff (!nrst)
		!regRead |=> regRdData == irs_pkg::UNMAPPED_READ;
	endproperty
	a_read_idle_zero: assert property (p_read_idle_zero) else $error("rdata not idle");

	property p_two_readback;
		@(posedge clk) disable iff (!nrst)
		(regRead && regAddr == irs_pkg::CH_TWO_ROUTING_ADDR)
			|=> regRdData == $past(routing_q[0]);
	endproperty
	a_two_readback: assert property (p_two_readback) else $error("ch two read wrong");

	property p_three_readback;
		@(posedge clk) disable iff (!nrst)
		(regRead && regAddr == irs_pkg::CH_THREE_ROUTING_ADDR)
			|=> regRdData == $past(routing_q[1]);
	endproperty
	a_three_readback: assert property (p_three_readback) else $error("ch three read wrong");

	property p_unmapped_write;
		@(posedge clk) disable iff (!nrst)
		(regWrite && (regAddr < irs_pkg::CH_TWO_ROUTING_ADDR
			|| regAddr > irs_pkg::PACING_ROUTING_ADDR))
			|=> routing_q[0] == $past(routing_q[0]) && routing_q[1] == $past(routing_q[1])
			&& routing_q[2] == $past(routing_q[2]);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("stray write landed");

	property p_plus_onehot;
		@(posedge clk) disable iff (!nrst)
		(routing_q[0][7:6] == irs_pkg::TEST_NONE && routing_q[0][5:3] != irs_pkg::SOURCE_OPEN
			&& routing_q[0][5:3] <= irs_pkg::SOURCE_LAST)
			|-> chTwoPlusSwitch == (5'h01 << (routing_q[0][5:3] - 3'h1));
	endproperty
	a_plus_onehot: assert property (p_plus_onehot) else $error("plus switch wrong");

	property p_minus_spare;
		@(posedge clk) disable iff (!nrst)
		routing_q[0][2:0] > irs_pkg::SOURCE_LAST |-> chTwoMinusSwitch == 5'h00;
	endproperty
	a_minus_spare: assert property (p_minus_spare) else $error("spare code closed a switch");

	property p_zero_test;
		@(posedge clk) disable iff (!nrst)
		routing_q[1][7:6] == irs_pkg::TEST_ZERO
			|-> chThreeTestSwitch == 3'h4 && chThreeMinusSwitch == 5'h00;
	endproperty
	a_zero_test: assert property (p_zero_test) else $error("zero test decode wrong");

	property p_reset_regs;
		@(posedge clk)
		!nrst |=> routing_q[0] == irs_pkg::ROUTING_RESET && routing_q[1] == irs_pkg::ROUTING_RESET
			&& routing_q[2] == irs_pkg::ROUTING_RESET && regRdData == irs_pkg::UNMAPPED_READ;
	endproperty
	a_reset_regs: assert property (p_reset_regs) else $error("reset left a value");

	property p_minus_single;
		@(posedge clk) disable iff (!nrst)
		$onehot0(chTwoMinusSwitch) && $onehot0(chThreeMinusSwitch) && $onehot0(pacingMinusSwitch);
	endproperty
	a_minus_single: assert property (p_minus_single) else $error("two minus switches on");
endmodule

// ---- bench/tb_irs_routing_ctrl.sv ----
/*
 Self-checking bench for the routing control registers and their switch decode.
 Assumes the register port answers reads one cycle later and switches are combinational.
*/
`timescale 1ns/1ns
module tb_irs_routing_ctrl;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdData;
	wire [38:0] swAll;
	logic [7:0] last [3];
	logic [7:0] d;
	int errors = 0;
	int n_checks = 0;
	always #20 clk = ~clk;
	irs_routing_ctrl irs_routing_ctrl_i (
		.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.chTwoPlusSwitch(swAll[38:34]), .chTwoMinusSwitch(swAll[33:29]),
		.chTwoTestSwitch(swAll[28:26]), .chThreePlusSwitch(swAll[25:21]),
		.chThreeMinusSwitch(swAll[20:16]), .chThreeTestSwitch(swAll[15:13]),
		.pacingPlusSwitch(swAll[12:8]), .pacingMinusSwitch(swAll[7:3]),
		.pacingTestSwitch(swAll[2:0])
	);
	// Selector decode, test overrides sources
	function automatic logic [12:0] expect_sw(input logic [7:0] v);
		logic [4:0] p;
		logic [4:0] m;
		logic [2:0] t;
		p = 5'h00;
		m = 5'h00;
		t = 3'h0;
		if (v[7:6] == irs_pkg::TEST_NONE) begin
			if (v[5:3] != 3'h0 && v[5:3] <= irs_pkg::SOURCE_LAST) p = 5'h01 << (v[5:3] - 3'h1);
			if (v[2:0] != 3'h0 && v[2:0] <= irs_pkg::SOURCE_LAST) m = 5'h01 << (v[2:0] - 3'h1);
		end else begin
			t = 3'h1 << (v[7:6] - 2'h1);
		end
		return {p, m, t};
	endfunction
	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 v = regRdData;
	endtask
	// Write then read back on the next cycle, no idle gap
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 r = regRdData;
	endtask
	// Every channel against its last written value
	task automatic check_all();
		for (int c = 0; c < 3; c++) begin
			check(swAll[38 - 13 * c -: 13], expect_sw(last[c]));
		end
	endtask
	task automatic report_and_stop();
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		errors++;
		report_and_stop();
	end
	initial begin
		last = '{8'h00, 8'h00, 8'h00};
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (int c = 0; c < 3; c++) begin
			rd(8'h02 + 8'(c), d);
			check({5'h00, d}, 13'h0000);
		end
		check_all();
		// Every value through every register
		for (int c = 0; c < 3; c++) begin
			for (int v = 0; v < 256; v++) begin
				wr(8'h02 + 8'(c), 8'(v));
				last[c] = 8'(v);
				check_all();
				rd(8'h02 + 8'(c), d);
				check({5'h00, d}, {5'h00, 8'(v)});
			end
			wr(8'h02 + 8'(c), 8'h08 * 8'(c + 1) + 8'(c + 1));
			last[c] = 8'h08 * 8'(c + 1) + 8'(c + 1);
			check_all();
		end
		// Unmapped place leaves routing alone
		wr(8'h05, 8'hFF);
		check_all();
		rd(8'h05, d);
		check({5'h00, d}, 13'h0000);
		rd(8'h03, d);
		check({5'h00, d}, {5'h00, last[1]});
		@(posedge clk);
		#1 check({5'h00, regRdData}, 13'h0000);
		// Write then read with no gap returns the new value
		wr_rd(8'h04, 8'hC5, d);
		last[2] = 8'hC5;
		check({5'h00, d}, {5'h00, 8'hC5});
		check_all();
		// Reset in mid-run clears every selector
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		#1;
		last = '{8'h00, 8'h00, 8'h00};
		check_all();
		rd(8'h04, d);
		check({5'h00, d}, 13'h0000);
		report_and_stop();
	end
endmodule
